// file: src/bise_exec.sv
// Purpose: executes i/o, stack, atomic ram, shift and flag operations
// Assumes: decoder delivers op, operands and register values on issue
// Notes:   results return on a one-cycle done pulse with the result byte
//
// Chosen here: the strobed register port and the register addresses.
`include "bise_defines.svh"
module bise_exec
	import bise_pkg::*;
#(
	parameter int AW = 6 // ram address width
) (
	// clock, enable and reset
	input  wire logic          i_clk,
	input  wire logic          i_ce,
	input  wire logic          i_arst_n,
	// instruction issue
	input  wire logic          i_issue,
	input  wire bise_op_t      i_op,
	input  wire logic [7:0]    i_rd_val,
	input  wire logic [AW-1:0] i_z_ptr,
	input  wire logic [5:0]    i_io_addr,
	input  wire logic [2:0]    i_bit_sel,
	input  wire logic          i_sram_target,
	// i/o register space
	input  wire logic [7:0]    i_io_rdata,
	output logic               o_io_we,
	output logic      [5:0]    o_io_addr,
	output logic      [7:0]    o_io_wdata,
	// results
	output logic               o_done,
	output logic               o_busy,
	output logic      [7:0]    o_result,
	output logic               o_result_we,
	output logic      [7:0]    o_status_flags_register,
	output logic      [AW-1:0] o_stack_ptr
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	bise_state_t     state_reg, state_next;   // sequencer
	bise_op_t        op_reg;                  // latched operation
	logic [7:0]      temp_reg;                // original register value
	logic [7:0]      status_flags_register_reg, status_flags_register_next;     // status flags
	logic [AW-1:0]   sp_reg, sp_next;         // stack pointer
	logic [AW-1:0]   addr_reg;                // latched ram address
	logic            extra_reg;               // one sram extra cycle owed
	logic [7:0]      mem_rdata;               // registered memory read
	logic            mem_we;                  // memory write enable
	logic [AW-1:0]   mem_waddr;               // memory write address
	logic [7:0]      mem_wdata;               // memory write data
	logic [AW-1:0]   mem_raddr;               // memory read address

	// ----------------------------------------
	// shift unit helpers
	// ----------------------------------------
	// zero flag of a result
	function automatic logic is_zero(input logic [7:0] v);
		return (v == 8'h00);
	endfunction

	// flags of a shift: z c n v s from result and carry out
	function automatic logic [7:0] shift_flags(input logic [7:0] old,
		input logic [7:0] res, input logic cout);
		logic [7:0] f;
		f = old;
		f[`BISE_FLAG_Z] = is_zero(res);
		f[`BISE_FLAG_C] = cout;
		f[`BISE_FLAG_N] = res[7];
		f[`BISE_FLAG_V] = res[7] ^ cout;
		f[`BISE_FLAG_S] = res[7] ^ (res[7] ^ cout);
		return f;
	endfunction

	wire logic       carry_in   = status_flags_register_reg[`BISE_FLAG_C];
	wire logic [7:0] rot_l      = {i_rd_val[6:0], carry_in};
	wire logic [7:0] rot_r      = {carry_in, i_rd_val[7:1]};
	wire logic [7:0] shl        = {i_rd_val[6:0], 1'b0};
	wire logic [7:0] shr        = {1'b0, i_rd_val[7:1]};
	wire logic [7:0] arith_shift_right        = {i_rd_val[7], i_rd_val[7:1]};
	wire logic [7:0] nib_swap   = {i_rd_val[3:0], i_rd_val[7:4]};
	wire logic [7:0] bit_mask   = 8'h01 << i_bit_sel;
	wire logic [7:0] tflag_ins  = status_flags_register_reg[`BISE_FLAG_T] ? (i_rd_val | bit_mask)
	                                                     : (i_rd_val & ~bit_mask);
	wire logic       is_ram_op  = (i_op == BISE_OP_RAM_EXCHANGE) ||
	                              (i_op == BISE_OP_LOAD_AND_SET) ||
	                              (i_op == BISE_OP_LOAD_AND_CLEAR) ||
	                              (i_op == BISE_OP_LOAD_AND_TOGGLE);
	wire logic       is_pop     = (i_op == BISE_OP_POP);
	wire logic       start      = i_issue && (state_reg == BISE_ST_IDLE);

	// ----------------------------------------
	// write-back value of atomic ram ops
	// ----------------------------------------
	logic [7:0] rmw_value;
	always_comb begin
		unique case (op_reg)
			BISE_OP_LOAD_AND_SET:    rmw_value = temp_reg | mem_rdata;
			BISE_OP_LOAD_AND_CLEAR:  rmw_value = (8'hff - temp_reg) & mem_rdata;
			BISE_OP_LOAD_AND_TOGGLE: rmw_value = temp_reg ^ mem_rdata;
			default:                 rmw_value = temp_reg;
		endcase
	end

	// ----------------------------------------
	// sequencer next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			BISE_ST_IDLE: begin
				if (start && (is_ram_op || is_pop)) begin
					// sram target owes one extra cycle
					state_next = i_sram_target ? BISE_ST_WAIT : BISE_ST_FINISH;
				end
			end
			BISE_ST_WAIT:   state_next = BISE_ST_FINISH;
			BISE_ST_FINISH: state_next = BISE_ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// status flag next value
	// ----------------------------------------
	always_comb begin
		status_flags_register_next = status_flags_register_reg;
		if (start) begin
			unique case (i_op)
				BISE_OP_SHIFT_LEFT_LOGICAL: begin
					status_flags_register_next = shift_flags(status_flags_register_reg, shl, i_rd_val[7]);
					status_flags_register_next[`BISE_FLAG_H] = i_rd_val[3];
				end
				BISE_OP_SHIFT_RIGHT_LOGICAL:
					status_flags_register_next = shift_flags(status_flags_register_reg, shr, i_rd_val[0]);
				BISE_OP_ROTATE_LEFT_CARRY: begin
					status_flags_register_next = shift_flags(status_flags_register_reg, rot_l, i_rd_val[7]);
					status_flags_register_next[`BISE_FLAG_H] = i_rd_val[3];
				end
				BISE_OP_ROTATE_RIGHT_CARRY:
					status_flags_register_next = shift_flags(status_flags_register_reg, rot_r, i_rd_val[0]);
				BISE_OP_ARITH_SHIFT_RIGHT:
					status_flags_register_next = shift_flags(status_flags_register_reg, arith_shift_right, i_rd_val[0]);
				// bit select names the flag; covers s, v, h, c, z, n, t, i
				BISE_OP_FLAG_SET:   status_flags_register_next[i_bit_sel] = 1'b1;
				BISE_OP_FLAG_CLEAR: status_flags_register_next[i_bit_sel] = 1'b0;
				BISE_OP_REG_BIT_TO_TFLAG:
					status_flags_register_next[`BISE_FLAG_T] = i_rd_val[i_bit_sel];
				default: status_flags_register_next = status_flags_register_reg; // all other ops keep flags
			endcase
		end
	end

	// ----------------------------------------
	// stack pointer and memory port selection
	// ----------------------------------------
	always_comb begin
		sp_next = sp_reg;
		if (start && (i_op == BISE_OP_PUSH)) begin
			sp_next = sp_reg - AW'(1);
		end else if (start && is_pop) begin
			sp_next = sp_reg + AW'(1);
		end
	end

	// pop reads one above the pointer; later re-reads use the latched address,
	// because the pointer has already moved and the issue inputs may have changed
	wire logic [AW-1:0] pop_addr = sp_reg + AW'(1);
	assign mem_raddr = start ? (is_pop ? pop_addr : i_z_ptr) : addr_reg;
	assign mem_we    = (start && (i_op == BISE_OP_PUSH)) ||
	                   ((state_reg == BISE_ST_FINISH) && (op_reg != BISE_OP_POP));
	assign mem_waddr = start ? sp_reg : addr_reg;
	assign mem_wdata = start ? i_rd_val : rmw_value;

	// ----------------------------------------
	// single-cycle result select
	// ----------------------------------------
	logic [7:0] quick_result;
	logic       quick_we;
	always_comb begin
		quick_result = i_rd_val;
		quick_we     = 1'b1;
		unique case (i_op)
			BISE_OP_IO_READ:             quick_result = i_io_rdata;
			BISE_OP_SHIFT_LEFT_LOGICAL:  quick_result = shl;
			BISE_OP_SHIFT_RIGHT_LOGICAL: quick_result = shr;
			BISE_OP_ROTATE_LEFT_CARRY:   quick_result = rot_l;
			BISE_OP_ROTATE_RIGHT_CARRY:  quick_result = rot_r;
			BISE_OP_ARITH_SHIFT_RIGHT:   quick_result = arith_shift_right;
			BISE_OP_NIBBLE_SWAP:         quick_result = nib_swap;
			BISE_OP_TFLAG_TO_REG_BIT:    quick_result = tflag_ins;
			default:                     quick_we     = 1'b0;
		endcase
	end

	// i/o write side: whole byte or one bit forced
	wire logic io_we_next = start && ((i_op == BISE_OP_IO_WRITE) ||
	                        (i_op == BISE_OP_IO_BIT_SET) || (i_op == BISE_OP_IO_BIT_CLEAR));
	logic [7:0] io_wdata_next;
	always_comb begin
		unique case (i_op)
			BISE_OP_IO_BIT_SET:   io_wdata_next = i_io_rdata | bit_mask;
			BISE_OP_IO_BIT_CLEAR: io_wdata_next = i_io_rdata & ~bit_mask;
			default:              io_wdata_next = i_rd_val;
		endcase
	end

	wire logic multi = is_ram_op || is_pop;

	// ----------------------------------------
	// memory instance
	// ----------------------------------------
	bise_data_mem #(.AW(AW)) u_mem (
		.i_clk   (i_clk),
		.i_ce    (i_ce),
		.i_we    (mem_we),
		.i_waddr (mem_waddr),
		.i_wdata (mem_wdata),
		.i_raddr (mem_raddr),
		.o_rdata (mem_rdata)
	);

	// ----------------------------------------
	// sequencer and flag registers
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg <= BISE_ST_IDLE;
			status_flags_register_reg  <= `BISE_STATUS_FLAGS_REGISTER_RST;
			sp_reg    <= AW'(`BISE_STACK_RST);
		end else if (i_ce) begin
			state_reg <= state_next;
			status_flags_register_reg  <= status_flags_register_next;
			sp_reg    <= sp_next;
		end
	end

	// operand capture at issue
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			op_reg    <= BISE_OP_NOP;
			temp_reg  <= 8'h00;
			addr_reg  <= '0;
			extra_reg <= 1'b0;
		end else if (i_ce && start) begin
			op_reg    <= i_op;
			temp_reg  <= i_rd_val;     // temp keeps original
			addr_reg  <= is_pop ? pop_addr : i_z_ptr; // address kept for wait re-read
			extra_reg <= i_sram_target;
		end
	end

	// ----------------------------------------
	// output registers
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_done      <= 1'b0;
			o_busy      <= 1'b0;
			o_result    <= 8'h00;
			o_result_we <= 1'b0;
			o_io_we     <= 1'b0;
			o_io_addr   <= 6'h00;
			o_io_wdata  <= 8'h00;
		end else if (i_ce) begin
			o_io_we   <= io_we_next;
			o_io_addr <= i_io_addr;
			o_io_wdata <= io_wdata_next;
			o_busy    <= (state_next != BISE_ST_IDLE);
			if (start && !multi) begin
				o_done      <= 1'b1;
				o_result    <= quick_result;
				o_result_we <= quick_we;
			end else if (state_reg == BISE_ST_FINISH) begin
				o_done      <= 1'b1;
				o_result    <= mem_rdata;             // old ram byte
				o_result_we <= 1'b1;
			end else begin
				o_done      <= 1'b0;
				o_result_we <= 1'b0;
			end
		end
	end

	assign o_status_flags_register = status_flags_register_reg;
	assign o_stack_ptr             = sp_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n || !i_ce);

	sequence s_multi_issue;
		start && multi && !i_sram_target;
	endsequence
	sequence s_two_cycle_done;
		##1 !o_done ##1 o_done;
	endsequence

	a_single_cycle_done: assert property (start && !multi |=> o_done)
		else $error("single cycle op did not finish in one cycle");
	a_push_sp_step: assert property (start && i_op == BISE_OP_PUSH |=>
		sp_reg == $past(sp_reg) - AW'(1))
		else $error("push did not move stack pointer");
	a_atomic_two_cycle: assert property (s_multi_issue |-> s_two_cycle_done)
		else $error("atomic op did not finish in two cycles");
	a_pop_two_cycle: assert property (start && is_pop && !i_sram_target |-> s_two_cycle_done)
		else $error("pop did not finish in two cycles");
	a_sram_extra: assert property (start && multi && i_sram_target |=> !o_done ##1 !o_done ##1 o_done)
		else $error("sram access lacked its extra cycle");
	a_rol_carry: assert property (start && i_op == BISE_OP_ROTATE_LEFT_CARRY |=>
		status_flags_register_reg[`BISE_FLAG_C] == $past(i_rd_val[7]) && o_result[0] == $past(carry_in))
		else $error("rotate left carry wrong");
	a_ror_keeps_h: assert property (start && i_op == BISE_OP_ROTATE_RIGHT_CARRY |=>
		$stable(status_flags_register_reg[`BISE_FLAG_H]) && o_result[7] == $past(carry_in))
		else $error("rotate right changed half carry");
	a_io_flags_kept: assert property (start && (i_op == BISE_OP_IO_READ ||
		i_op == BISE_OP_IO_BIT_SET || i_op == BISE_OP_IO_BIT_CLEAR) |=> $stable(status_flags_register_reg))
		else $error("io op changed flags");
	a_bit_store_t: assert property (start && i_op == BISE_OP_REG_BIT_TO_TFLAG |=>
		status_flags_register_reg[`BISE_FLAG_T] == $past(i_rd_val[i_bit_sel]))
		else $error("bit store did not reach T");
	a_flag_set_one: assert property (start && i_op == BISE_OP_FLAG_SET |=>
		status_flags_register_reg == ($past(status_flags_register_reg) | (8'h01 << $past(i_bit_sel))))
		else $error("flag set touched other bits");

endmodule // bise_exec

// file: src/bise_defines.svh
// Purpose: constants for the bit, i/o and stack execution unit
// Assumes: 8-bit data, AW-bit data-space addresses (6-bit by default)
// Notes:   status flag positions follow the usual i t h s v n z c order
`ifndef BISE_DEFINES_SVH
`define BISE_DEFINES_SVH

// ----------------------------------------
// status flag bit positions
// ----------------------------------------
`define BISE_FLAG_C 3'd0
`define BISE_FLAG_Z 3'd1
`define BISE_FLAG_N 3'd2
`define BISE_FLAG_V 3'd3
`define BISE_FLAG_S 3'd4
`define BISE_FLAG_H 3'd5
`define BISE_FLAG_T 3'd6
`define BISE_FLAG_I 3'd7

// ----------------------------------------
// reset values and cycle counts
// ----------------------------------------
`define BISE_STATUS_FLAGS_REGISTER_RST   8'h00
`define BISE_STACK_RST  8'hff
`define BISE_SRAM_EXTRA 2'd1

`endif

// file: src/bise_pkg.sv
// Purpose: types for the bit, i/o and stack execution unit
// Assumes: one instruction is presented per accepted issue strobe
// Notes:   opcode list is the block's own decoded form
package bise_pkg;

	// decoded operations handled by this unit
	typedef enum logic [4:0] {
		BISE_OP_NOP,
		BISE_OP_IO_READ,
		BISE_OP_IO_WRITE,
		BISE_OP_PUSH,
		BISE_OP_POP,
		BISE_OP_RAM_EXCHANGE,
		BISE_OP_LOAD_AND_SET,
		BISE_OP_LOAD_AND_CLEAR,
		BISE_OP_LOAD_AND_TOGGLE,
		BISE_OP_SHIFT_LEFT_LOGICAL,
		BISE_OP_SHIFT_RIGHT_LOGICAL,
		BISE_OP_ROTATE_LEFT_CARRY,
		BISE_OP_ROTATE_RIGHT_CARRY,
		BISE_OP_ARITH_SHIFT_RIGHT,
		BISE_OP_NIBBLE_SWAP,
		BISE_OP_FLAG_SET,
		BISE_OP_FLAG_CLEAR,
		BISE_OP_IO_BIT_SET,
		BISE_OP_IO_BIT_CLEAR,
		BISE_OP_REG_BIT_TO_TFLAG,
		BISE_OP_TFLAG_TO_REG_BIT
	} bise_op_t;

	// execution sequencer states
	typedef enum logic [1:0] {
		BISE_ST_IDLE,
		BISE_ST_WAIT,
		BISE_ST_FINISH
	} bise_state_t;

endpackage : bise_pkg

// file: src/bise_data_mem.sv
// Purpose: small data memory holding ram bytes and the stack
// Assumes: one write and one registered read per cycle
// Notes:   read data appear the cycle after the read address
module bise_data_mem #(
	parameter int AW = 6
) (
	// clock
	input  wire logic          i_clk,
	input  wire logic          i_ce,
	// write port
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [7:0]    i_wdata,
	// read port
	input  wire logic [AW-1:0] i_raddr,
	output logic      [7:0]    o_rdata
);

	logic [7:0] mem [0:(1<<AW)-1]; // storage array

	// ----------------------------------------
	// write and registered read
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			if (i_we) begin
				mem[i_waddr] <= i_wdata;
			end
			o_rdata <= mem[i_raddr];
		end
	end

endmodule // bise_data_mem

// file: tb/bise_io_model.sv
// Purpose: i/o register space seen by the execution unit
// Assumes: reads are combinational from the issue address
// Notes:   contents preset to a known pattern, never unknown
module bise_io_model #(
	parameter int DEPTH = 64 // number of i/o locations
) (
	// clock
	input  wire logic       i_clk,
	// read side
	input  wire logic [5:0] i_raddr,
	output logic      [7:0] o_rdata,
	// write side
	input  wire logic       i_we,
	input  wire logic [5:0] i_waddr,
	input  wire logic [7:0] i_wdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] regs [DEPTH]; // i/o locations

	// known start pattern so reads never show unknowns
	initial begin
		for (int k = 0; k < DEPTH; k++) begin
			regs[k] = 8'(k) ^ 8'h5a;
		end
	end

	// registered write on the unit's write pulse
	always @(posedge i_clk) begin
		if (i_we === 1'b1) begin
			regs[i_waddr] <= i_wdata;
		end
	end

	assign o_rdata = regs[i_raddr]; // current contents of addressed location
endmodule // bise_io_model

// file: tb/bise_exec_test.sv
// Purpose: self-checking bench for the execution unit
// Assumes: internal memory, i_ce high except during the closing clock-enable check
// Notes:   flags tracked in exp_f, checked against it after flag, shift and bit ops and selected i/o, stack and ram ops
`include "bise_defines.svh"
module bise_exec_test
	import bise_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic       i_clk, i_ce, i_arst_n, i_issue, i_sram_target;
	bise_op_t   i_op;
	logic [7:0] i_rd_val, i_io_rdata, o_io_wdata, o_result, o_status_flags_register;
	logic [5:0] i_z_ptr, i_io_addr, o_io_addr, o_stack_ptr;
	logic [2:0] i_bit_sel;
	logic       o_io_we, o_done, o_busy, o_result_we;
	int         bad_count, compares, cyc, n;
	logic [7:0] exp_f, res_q, flg_q, iod_q; // expected flags, captured outputs
	logic [5:0] ioa_q;
	logic       iowe_q, rwe_q;

	bise_exec #(.AW(6)) i_dut (
		.i_clk(i_clk), .i_ce(i_ce), .i_arst_n(i_arst_n), .i_issue(i_issue),
		.i_op(i_op), .i_rd_val(i_rd_val), .i_z_ptr(i_z_ptr), .i_io_addr(i_io_addr),
		.i_bit_sel(i_bit_sel), .i_sram_target(i_sram_target), .i_io_rdata(i_io_rdata),
		.o_io_we(o_io_we), .o_io_addr(o_io_addr), .o_io_wdata(o_io_wdata),
		.o_done(o_done), .o_busy(o_busy), .o_result(o_result), .o_result_we(o_result_we),
		.o_status_flags_register(o_status_flags_register), .o_stack_ptr(o_stack_ptr)
	);

	bise_io_model i_io (
		.i_clk(i_clk), .i_raddr(i_io_addr), .o_rdata(i_io_rdata),
		.i_we(o_io_we), .i_waddr(o_io_addr), .i_wdata(o_io_wdata)
	);

	// ----------------------------------------
	// clock and timeout
	// ----------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	// cut a hang short
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			$display("CHECK FAILED at %0t: run timed out", $time);
			print_verdict();
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// issue one op, wait for done, then for idle
	task automatic run(input bise_op_t op, input logic [7:0] rd, input logic [5:0] a,
			input logic [2:0] b, input logic sram, input int want);
		@(posedge i_clk);
		i_issue <= 1'b1;
		i_op <= op;
		i_rd_val <= rd;
		i_z_ptr <= a;
		i_io_addr <= a;
		i_bit_sel <= b;
		i_sram_target <= sram;
		@(posedge i_clk);
		i_issue <= 1'b0;
		#1;
		n = 1;
		while (o_done !== 1'b1 && n < 20) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		res_q = o_result;
		flg_q = o_status_flags_register;
		iowe_q = o_io_we;
		rwe_q = o_result_we;
		ioa_q = o_io_addr;
		iod_q = o_io_wdata;
		chk(16'(n), 16'(want), "cycle count");
		while (o_busy !== 1'b0 && n < 40) begin
			@(posedge i_clk);
			#1;
			n++;
		end
	endtask

	// expected {carry, result} of a shift-type op
	function automatic logic [8:0] shf(input bise_op_t op, input logic [7:0] x, input logic c);
		case (op)
			BISE_OP_ROTATE_LEFT_CARRY:   return {x[7], x[6:0], c};
			BISE_OP_SHIFT_LEFT_LOGICAL:  return {x[7], x[6:0], 1'b0};
			BISE_OP_ROTATE_RIGHT_CARRY:  return {x[0], c, x[7:1]};
			BISE_OP_SHIFT_RIGHT_LOGICAL: return {x[0], 1'b0, x[7:1]};
			BISE_OP_ARITH_SHIFT_RIGHT:   return {x[0], x[7], x[7:1]};
			default:                     return {c, x[3:0], x[7:4]};
		endcase
	endfunction

	// shift-type op with result and flag check
	task automatic shift(input bise_op_t op, input logic [7:0] x);
		logic [8:0] e;
		e = shf(op, x, exp_f[`BISE_FLAG_C]);
		run(op, x, 6'h00, 3'h0, 1'b0, 1);
		if (op != BISE_OP_NIBBLE_SWAP) begin
			exp_f[`BISE_FLAG_C] = e[8];
			exp_f[`BISE_FLAG_Z] = (e[7:0] == 8'h00);
			exp_f[`BISE_FLAG_N] = e[7];
			exp_f[`BISE_FLAG_V] = e[7] ^ e[8];
			exp_f[`BISE_FLAG_S] = e[8];
			if (op == BISE_OP_ROTATE_LEFT_CARRY || op == BISE_OP_SHIFT_LEFT_LOGICAL) begin
				exp_f[`BISE_FLAG_H] = x[3];
			end
		end
		chk(16'(res_q), 16'(e[7:0]), "shift result");
		chk(16'(flg_q), 16'(exp_f), "shift flags");
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{i_issue, i_sram_target, i_rd_val, i_z_ptr, i_io_addr, i_bit_sel} = '0;
		i_op = BISE_OP_NOP;
		i_ce = 1'b1;
		i_arst_n = 1'b0;
		exp_f = 8'h00;
		repeat (16) @(posedge i_clk);
		i_arst_n <= 1'b1;
		#1;
		chk(16'(o_stack_ptr), 16'h003f, "stack reset");
		chk(16'(o_status_flags_register), 16'h0000, "flag reset");
		// every flag set then cleared, only that bit moves
		for (int k = 0; k < 16; k++) begin
			run(k < 8 ? BISE_OP_FLAG_SET : BISE_OP_FLAG_CLEAR, 8'h00, 6'h00, 3'(k), 1'b0, 1);
			exp_f[k % 8] = (k < 8);
			chk(16'(flg_q), 16'(exp_f), "flag set/clear");
		end
		run(BISE_OP_FLAG_SET, 8'h00, 6'h00, 3'h0, 1'b0, 1);
		exp_f[`BISE_FLAG_C] = 1'b1;
		// shifts, rotates through carry, swap
		shift(BISE_OP_ROTATE_LEFT_CARRY, 8'h81);
		shift(BISE_OP_ROTATE_LEFT_CARRY, 8'h08);
		shift(BISE_OP_ROTATE_RIGHT_CARRY, 8'h01);
		shift(BISE_OP_ROTATE_RIGHT_CARRY, 8'h02);
		shift(BISE_OP_SHIFT_LEFT_LOGICAL, 8'h88);
		shift(BISE_OP_SHIFT_RIGHT_LOGICAL, 8'h81);
		shift(BISE_OP_ARITH_SHIFT_RIGHT, 8'h80);
		shift(BISE_OP_NIBBLE_SWAP, 8'h3c);
		// bit store and bit load through t
		run(BISE_OP_REG_BIT_TO_TFLAG, 8'h20, 6'h00, 3'h5, 1'b0, 1);
		exp_f[`BISE_FLAG_T] = 1'b1;
		chk(16'(flg_q), 16'(exp_f), "bit to t");
		run(BISE_OP_TFLAG_TO_REG_BIT, 8'h00, 6'h00, 3'h3, 1'b0, 1);
		chk(16'({res_q, flg_q}), {8'h08, exp_f}, "t to bit");
		run(BISE_OP_REG_BIT_TO_TFLAG, 8'hdf, 6'h00, 3'h5, 1'b0, 1);
		exp_f[`BISE_FLAG_T] = 1'b0;
		chk(16'(flg_q), 16'(exp_f), "bit to t clear");
		run(BISE_OP_TFLAG_TO_REG_BIT, 8'hff, 6'h00, 3'h7, 1'b0, 1);
		chk(16'({res_q, flg_q}), {8'h7f, exp_f}, "t to bit clear");
		// i/o write, read, bit set and clear
		run(BISE_OP_IO_WRITE, 8'h77, 6'h0a, 3'h0, 1'b0, 1);
		chk({7'h00, iowe_q, ioa_q, 2'h0}, {7'h00, 1'b1, 6'h0a, 2'h0}, "io write");
		chk(16'({iod_q, flg_q}), {8'h77, exp_f}, "io write data");
		chk(16'(rwe_q), 16'h0000, "io write no result");
		run(BISE_OP_IO_READ, 8'h00, 6'h0a, 3'h0, 1'b0, 1);
		chk(16'({res_q, flg_q}), {8'h77, exp_f}, "io read");
		chk(16'(rwe_q), 16'h0001, "io read result write");
		run(BISE_OP_IO_BIT_SET, 8'h00, 6'h0a, 3'h3, 1'b0, 1);
		chk(16'({iod_q, flg_q}), {8'h7f, exp_f}, "io bit set");
		chk(16'(iowe_q), 16'h0001, "io bit set strobe");
		run(BISE_OP_IO_BIT_CLEAR, 8'h00, 6'h0a, 3'h0, 1'b0, 1);
		chk(16'({iod_q, flg_q}), {8'h7e, exp_f}, "io bit clear");
		run(BISE_OP_IO_READ, 8'h00, 6'h0a, 3'h0, 1'b0, 1);
		chk(16'(res_q), 16'h007e, "io read back");
		// stack push and pop, last with the extra sram cycle
		run(BISE_OP_PUSH, 8'h5a, 6'h00, 3'h0, 1'b0, 1);
		chk(16'({2'h0, o_stack_ptr, flg_q}), {8'h3e, exp_f}, "push");
		chk(16'(rwe_q), 16'h0000, "push no result");
		run(BISE_OP_PUSH, 8'ha5, 6'h00, 3'h0, 1'b0, 1);
		run(BISE_OP_POP, 8'h00, 6'h00, 3'h0, 1'b0, 2);
		chk(16'({res_q, 2'h0, o_stack_ptr}), 16'ha53e, "pop");
		chk(16'(rwe_q), 16'h0001, "pop result write");
		run(BISE_OP_POP, 8'h00, 6'h00, 3'h0, 1'b1, 3);
		chk(16'({res_q, 2'h0, o_stack_ptr}), 16'h5a3f, "pop sram");
		chk(16'(flg_q), 16'(exp_f), "pop flags");
		// atomic ram chain at one address
		run(BISE_OP_RAM_EXCHANGE, 8'h3c, 6'h05, 3'h0, 1'b0, 2);
		run(BISE_OP_LOAD_AND_SET, 8'h0f, 6'h05, 3'h0, 1'b0, 2);
		chk(16'(res_q), 16'h003c, "exchange stored");
		run(BISE_OP_LOAD_AND_CLEAR, 8'h30, 6'h05, 3'h0, 1'b1, 3);
		chk(16'(res_q), 16'h003f, "set result");
		run(BISE_OP_LOAD_AND_TOGGLE, 8'hff, 6'h05, 3'h0, 1'b0, 2);
		chk(16'(res_q), 16'h000f, "clear result");
		run(BISE_OP_RAM_EXCHANGE, 8'h11, 6'h05, 3'h0, 1'b0, 2);
		chk(16'(res_q), 16'h00f0, "toggle result");
		run(BISE_OP_RAM_EXCHANGE, 8'h00, 6'h05, 3'h0, 1'b0, 2);
		chk(16'({res_q, flg_q}), {8'h11, exp_f}, "exchange swap");
		// clock enable low: an issued flag set must not land
		@(posedge i_clk);
		i_ce <= 1'b0;
		i_issue <= 1'b1;
		i_op <= BISE_OP_FLAG_SET;
		i_bit_sel <= 3'h7;
		repeat (2) @(posedge i_clk);
		i_issue <= 1'b0;
		i_ce <= 1'b1;
		#1;
		chk(16'({o_status_flags_register, 2'h0, o_stack_ptr}), {exp_f, 8'h3f}, "ce frozen");
		chk(16'(o_done), 16'h0000, "ce frozen done");
		print_verdict();
	end
endmodule // bise_exec_test
